// [logic/tsie_top.sv]
// Status word, interrupt flags, enable masking and interrupt pin driver behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "tsie_map.svh"

module tsie_top import tsie_pkg::*; #(
    parameter int ADDR_W = 18
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Device state levels
    input wire logic device_ready,
    input wire logic contactless_activity,
    input wire logic crc_active,
    // Received Type 4 command
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_code,
    // Event pulses
    input wire logic crc_done_event,
    input wire logic parity_fault_event,
    input wire logic field_loss_event,
    input wire logic generic_error_event,
    input wire logic prefetch_event,
    // Interrupt
    output logic irq,
    output logic int_pin_out,
    output logic int_pin_oe
);

    // Apply the 2-bit byte enables of a write onto a stored 16-bit word
    function automatic tsie_word_t merge_bytes(input tsie_word_t old_val, input tsie_word_t new_val,
                                               input logic [1:0] strb);
        tsie_word_t res;
        res = old_val;
        if (strb[0]) begin
            res[7:0] = new_val[7:0];
        end
        if (strb[1]) begin
            res[15:8] = new_val[15:8];
        end
        return res;
    endfunction

    // Turn a byte address into a register index; the two low address bits are dropped
    function automatic logic [ADDR_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
        return {2'h0, addr[ADDR_W-1:2]};
    endfunction

    // Any mapped index
    function automatic logic is_mapped(input logic [ADDR_W-1:0] idx);
        return (idx == `TSIE_IDX_CTRL) || (idx == `TSIE_IDX_CLEAR) || (idx == `TSIE_IDX_FLAG) ||
               (idx == `TSIE_IDX_ENABLE) || (idx == `TSIE_IDX_STATUS);
    endfunction

    // Usable access: a mapped word at an aligned byte address; anything else gets a decode error
    function automatic logic addr_ok(input logic [ADDR_W-1:0] addr);
        return is_mapped(reg_index(addr)) && (addr[1:0] == 2'h0);
    endfunction

    // Registers
    tsie_word_t enable_reg;
    tsie_word_t flag_reg;
    tsie_word_t ctrl_reg;
    tsie_cmd_t cmd_reg;
    logic ready_reg;
    logic activity_reg;
    logic crc_reg;

    // Write channel holding
    logic aw_full_reg;
    logic w_full_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    tsie_word_t w_data_reg;
    logic [1:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    // Read channel
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Derived
    logic wr_fire;
    logic [ADDR_W-1:0] wr_idx;
    logic [ADDR_W-1:0] rd_idx;
    tsie_word_t clear_mask;
    tsie_word_t event_vec;
    tsie_word_t status_word;
    tsie_word_t flag_next;
    logic pending;
    logic wr_ok;
    logic rd_ok;
    logic wr_enable_hit;
    logic wr_ctrl_hit;
    logic wr_clear_hit;
    tsie_word_t rd_word;

    // Ready stays low while a response waits, so a second write cannot overtake the first
    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = !w_full_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Protection attributes carry no meaning here; every access is treated alike
    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_idx = reg_index(aw_addr_reg);
    assign rd_idx = reg_index(s_axi_araddr);
    assign wr_ok = addr_ok(aw_addr_reg);
    assign rd_ok = addr_ok(s_axi_araddr);

    // Write decode: a word is only touched when its address is aligned and mapped
    assign wr_enable_hit = wr_fire && wr_ok && (wr_idx == `TSIE_IDX_ENABLE);
    assign wr_ctrl_hit = wr_fire && wr_ok && (wr_idx == `TSIE_IDX_CTRL);
    assign wr_clear_hit = wr_fire && wr_ok && (wr_idx == `TSIE_IDX_FLAG || wr_idx == `TSIE_IDX_CLEAR);

    // Address and data may arrive in either order; each is parked until both are present
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 16'h0000;
            w_strb_reg <= 2'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[15:0];
            w_strb_reg <= s_axi_wstrb[1:0];
        end else if (wr_fire) begin
            w_full_reg <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer with a decode error and change nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `TSIE_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? `TSIE_RESP_OKAY : `TSIE_RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= `TSIE_RST_ENABLE;
        end else if (wr_enable_hit) begin
            enable_reg <= merge_bytes(enable_reg, w_data_reg, w_strb_reg) & `TSIE_EV_MASK;
        end
    end

    // Control word: global enable, polarity and drive of the interrupt pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `TSIE_RST_CTRL;
        end else if (wr_ctrl_hit) begin
            ctrl_reg <= merge_bytes(ctrl_reg, w_data_reg, w_strb_reg) & `TSIE_CTL_MASK;
        end
    end

    // write-one clears, from the flag word or its clear alias
    always_comb begin
        clear_mask = 16'h0000;
        if (wr_clear_hit) begin
            clear_mask = merge_bytes(16'h0000, w_data_reg, w_strb_reg) & `TSIE_EV_MASK;
        end
    end

    always_comb begin
        event_vec = 16'h0000;
        event_vec[`TSIE_EV_CRC_DONE] = crc_done_event;
        event_vec[`TSIE_EV_PARITY] = parity_fault_event;
        event_vec[`TSIE_EV_REQUEST] = cmd_valid;
        event_vec[`TSIE_EV_FIELD_LOSS] = field_loss_event;
        event_vec[`TSIE_EV_GEN_ERROR] = generic_error_event;
        event_vec[`TSIE_EV_PREFETCH] = prefetch_event;
    end

    // sticky flags; an event in the clearing cycle survives the clear
    assign flag_next = (flag_reg & ~clear_mask) | event_vec;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= `TSIE_RST_FLAG;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // A command with code none still raises the request flag
    // command code is loaded with the general request flag, kept until the next one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= TSIE_CMD_NONE;
        end else if (cmd_valid) begin
            cmd_reg <= tsie_cmd_t'(cmd_code);
        end
    end

    // Registering the levels gives a read one consistent snapshot of all three
    // live state levels, one register stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_reg <= 1'b0;
            activity_reg <= 1'b0;
            crc_reg <= 1'b0;
        end else begin
            ready_reg <= device_ready;
            activity_reg <= contactless_activity;
            crc_reg <= crc_active;
        end
    end

    always_comb begin
        status_word = `TSIE_RST_STATUS;
        status_word[`TSIE_ST_READY] = ready_reg;
        status_word[`TSIE_ST_CRC] = crc_reg;
        status_word[`TSIE_ST_ACTIVITY] = activity_reg;
        status_word[`TSIE_ST_CMD_MSB:`TSIE_ST_CMD_LSB] = cmd_reg;
    end

    // Read word select; the clear alias, unmapped and misaligned words read zero
    always_comb begin
        rd_word = 16'h0000;
        if (rd_ok) begin
            unique case (rd_idx)
                `TSIE_IDX_STATUS: rd_word = status_word;
                `TSIE_IDX_ENABLE: rd_word = enable_reg;
                `TSIE_IDX_FLAG: rd_word = flag_reg;
                `TSIE_IDX_CTRL: rd_word = ctrl_reg;
                `TSIE_IDX_CLEAR: rd_word = 16'h0000;
                default: rd_word = 16'h0000;
            endcase
        end
    end

    // Read path: one register stage, bits 31..16 always zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `TSIE_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_ok ? `TSIE_RESP_OKAY : `TSIE_RESP_DECERR;
            rdata_reg <= {16'h0000, rd_word};
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign pending = |(flag_reg & enable_reg);

    // Pin and request are registered on the same edge so they never disagree
    // request gated by global enable, registered every cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= ctrl_reg[`TSIE_CTL_INT_EN] && pending;
        end
    end

    // Pin driver; idle level is only driven when drive mode asks, else an external resistor holds it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_pin_out <= 1'b0;
            int_pin_oe <= 1'b0;
        end else if (!ctrl_reg[`TSIE_CTL_INT_EN]) begin
            int_pin_out <= 1'b0;
            int_pin_oe <= 1'b0;
        end else if (pending) begin
            int_pin_out <= ctrl_reg[`TSIE_CTL_INT_HIGH];
            int_pin_oe <= 1'b1;
        end else begin
            int_pin_out <= !ctrl_reg[`TSIE_CTL_INT_HIGH];
            int_pin_oe <= ctrl_reg[`TSIE_CTL_INT_DRIVE];
        end
    end

endmodule

// [logic/tsie_map.svh]
// Register map, field positions and reset values of the tag status and interrupt enable block
`ifndef TSIE_MAP_SVH
`define TSIE_MAP_SVH

// Register indices; byte address is four times the index
`define TSIE_IDX_CTRL 18'h0FFF0
`define TSIE_IDX_CLEAR 18'h0FFF2
`define TSIE_IDX_FLAG 18'h0FFF8
`define TSIE_IDX_ENABLE 18'h0FFFA
`define TSIE_IDX_STATUS 18'h0FFFC

// Status word fields
`define TSIE_ST_READY 0
`define TSIE_ST_CRC 1
`define TSIE_ST_ACTIVITY 2
`define TSIE_ST_CMD_LSB 4
`define TSIE_ST_CMD_MSB 5

// Event bit positions, shared by flag, clear and enable words
`define TSIE_EV_CRC_DONE 3
`define TSIE_EV_PARITY 4
`define TSIE_EV_REQUEST 5
`define TSIE_EV_FIELD_LOSS 6
`define TSIE_EV_GEN_ERROR 7
`define TSIE_EV_PREFETCH 8
`define TSIE_EV_MASK 16'h01F8

// Control word fields
`define TSIE_CTL_INT_EN 2
`define TSIE_CTL_INT_HIGH 3
`define TSIE_CTL_INT_DRIVE 4
`define TSIE_CTL_MASK 16'h001C

// Reset values
`define TSIE_RST_ENABLE 16'h0000
`define TSIE_RST_STATUS 16'h0000
`define TSIE_RST_FLAG 16'h0000
`define TSIE_RST_CTRL 16'h0000

// Bus responses
`define TSIE_RESP_OKAY 2'h0
`define TSIE_RESP_DECERR 2'h3

`endif

// [logic/tsie_pkg.sv]
// Types of the tag status and interrupt enable block
package tsie_pkg;

    typedef logic [15:0] tsie_word_t;

    typedef enum logic [1:0] {
        TSIE_CMD_NONE,
        TSIE_CMD_SELECT,
        TSIE_CMD_READ,
        TSIE_CMD_UPDATE
    } tsie_cmd_t;

endpackage

// [verif/tsie_top_assertions.sv]
// Port checker for the status word and interrupt block
`timescale 1ns/10ps
`include "tsie_map.svh"
module tsie_chk #(
    parameter int ADDR_W = 18
) (
    input wire logic clk, rst_n, irq, int_pin_oe,
    input wire logic s_axi_awvalid, s_axi_wvalid, s_axi_awready, s_axi_wready, s_axi_bvalid,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic device_ready, contactless_activity, crc_active,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [31:0] s_axi_rdata
);
    localparam logic [ADDR_W-1:0] STATUS_A = `TSIE_IDX_STATUS << 2;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence st_rd;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == STATUS_A;
    endsequence
    oe_irq_a: assert property (irq |-> int_pin_oe)
        else $error("request up with pin released");
    // Status shows levels sampled one edge before the read is taken
    st_levels_a: assert property (st_rd |=> s_axi_rdata[2:0] ==
        {$past(contactless_activity, 2), $past(crc_active, 2), $past(device_ready, 2)})
        else $error("status levels wrong");
    st_resv_a: assert property (st_rd |=> s_axi_rdata[15:6] == 10'h000 && !s_axi_rdata[3])
        else $error("reserved status bits set");
    hi_half_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    irq_drop_a: assert property ($fell(irq) |-> $past(s_axi_bvalid))
        else $error("request fell without a write");
    cover property ($rose(irq));
    cover property (s_axi_rvalid && !s_axi_rready);
    cover property (st_rd);
endmodule
bind tsie_top tsie_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// [verif/tsie_host.sv]
// Host model: register bus master of the status and interrupt block
`timescale 1ns/10ps
module tsie_host (
    input wire logic clk,
    output logic [17:0] s_axi_awaddr, s_axi_araddr,
    output logic [2:0] s_axi_awprot, s_axi_arprot,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
    input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
    input wire logic [1:0] s_axi_bresp, s_axi_rresp,
    input wire logic [31:0] s_axi_rdata
);
    // Cycles to hold off taking read data, to test a slow host
    int stall = 0;
    // Byte lanes of the next write, to test partial writes
    logic [3:0] strb = 4'h3;
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [17:0] i, input logic [15:0] d, output logic [1:0] r);
        logic a, w, b;
        @(posedge clk);
        s_axi_awaddr <= {i[15:0], 2'h0};
        // upper half zero, lanes as set
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            a = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [17:0] i, output logic [15:0] d, output logic [1:0] r);
        logic a, v;
        @(posedge clk);
        s_axi_araddr <= {i[15:0], 2'h0};
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge clk);
            a = s_axi_arready;
            @(posedge clk);
        end while (!a);
        s_axi_arvalid <= 1'b0;
        repeat (stall) @(posedge clk);
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            v = s_axi_rvalid;
            d = s_axi_rdata[15:0];
            r = s_axi_rresp;
            @(posedge clk);
        end while (!v);
        s_axi_rready <= 1'b0;
    endtask
endmodule

// [verif/tb_tag_status_and_irq_enable.sv]
// Self-checking bench for the status word and interrupt block
`timescale 1ns/10ps
`include "tsie_map.svh"
module tb_tag_status_and_irq_enable import tsie_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [1:0] cmd_code = 2'h0;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, int_pin_out, int_pin_oe;
    logic device_ready = 1'b0, contactless_activity = 1'b0, crc_active = 1'b0;
    logic [8:3] ev = 6'h00;
    wire cmd_valid = ev[5], crc_done_event = ev[3], parity_fault_event = ev[4];
    wire field_loss_event = ev[6], generic_error_event = ev[7], prefetch_event = ev[8];
    int n_errors = 0;
    int checked = 0;
    tsie_top DUT (.*);
    tsie_host host (.*);
    always #2 clk = ~clk;
    task ck(tsie_word_t got, tsie_word_t exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(logic [17:0] i, tsie_word_t d);
        logic [1:0] r;
        host.wr(i, d, r);
        ck(r, `TSIE_RESP_OKAY);
    endtask
    task rdck(logic [17:0] i, tsie_word_t e);
        tsie_word_t d;
        logic [1:0] r;
        host.rd(i, d, r);
        ck(d, e);
        ck(r, `TSIE_RESP_OKAY);
    endtask
    task pulse(int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask
    task t_reset;
        rdck(`TSIE_IDX_ENABLE, 16'h0000);
        rdck(`TSIE_IDX_STATUS, 16'h0000);
        #1 ck(int_pin_oe, 16'h0000);
    endtask
    task t_status;
        @(posedge clk);
        device_ready <= 1'b1;
        contactless_activity <= 1'b1;
        rdck(`TSIE_IDX_STATUS, 16'h0005);
        contactless_activity <= 1'b0;
        crc_active <= 1'b1;
        rdck(`TSIE_IDX_STATUS, 16'h0003);
        crc_active <= 1'b0;
    endtask
    task t_cmd;
        wr(`TSIE_IDX_CTRL, 16'h0004);
        wr(`TSIE_IDX_ENABLE, 16'h0020);
        for (int c = 3; c >= 0; c--) begin
            @(posedge clk);
            cmd_code <= c[1:0];
            ev[5] <= 1'b1;
            @(posedge clk);
            ev[5] <= 1'b0;
            repeat (2) @(posedge clk);
            // Code is only read once the request interrupt is seen
            #1 ck(irq, 16'h0001);
            rdck(`TSIE_IDX_STATUS, {10'h000, c[1:0], 4'h1});
            wr(`TSIE_IDX_CLEAR, 16'h0020);
            #1 ck(irq, 16'h0000);
        end
    endtask
    task t_events;
        for (int i = 3; i <= 8; i++) begin
            if (i != 5) begin
                wr(`TSIE_IDX_ENABLE, 16'h0000);
                pulse(i);
                repeat (2) @(posedge clk);
                #1 ck(irq, 16'h0000);
                wr(`TSIE_IDX_FLAG, 16'h0000);
                rdck(`TSIE_IDX_FLAG, 16'h0001 << i);
                wr(`TSIE_IDX_ENABLE, 16'h0001 << i);
                #1 ck({irq, int_pin_out, int_pin_oe}, 16'h0005);
                wr(`TSIE_IDX_FLAG, 16'h0001 << i);
                #1 ck(irq, 16'h0000);
            end
        end
    endtask
    task t_pin;
        tsie_word_t d;
        logic [1:0] r;
        host.strb = 4'h1;
        wr(`TSIE_IDX_ENABLE, 16'h0000);
        rdck(`TSIE_IDX_ENABLE, 16'h0100);
        host.strb = 4'h2;
        wr(`TSIE_IDX_ENABLE, 16'h00F8);
        rdck(`TSIE_IDX_ENABLE, 16'h0000);
        host.strb = 4'h3;
        wr(`TSIE_IDX_ENABLE, 16'hFFFF);
        rdck(`TSIE_IDX_ENABLE, 16'h01F8);
        pulse(6);
        pulse(7);
        wr(`TSIE_IDX_CLEAR, 16'h0040);
        #1 ck(irq, 16'h0001);
        wr(`TSIE_IDX_CTRL, 16'h000C);
        #1 ck({int_pin_out, int_pin_oe}, 16'h0003);
        wr(`TSIE_IDX_CTRL, 16'h0000);
        #1 ck({irq, int_pin_oe}, 16'h0000);
        wr(`TSIE_IDX_CLEAR, 16'h0080);
        wr(`TSIE_IDX_CTRL, 16'h0014);
        #1 ck({irq, int_pin_out, int_pin_oe}, 16'h0003);
        wr(`TSIE_IDX_CTRL, 16'h001C);
        #1 ck({irq, int_pin_out, int_pin_oe}, 16'h0001);
        wr(`TSIE_IDX_STATUS, 16'hFFFF);
        host.stall = 3;
        rdck(`TSIE_IDX_STATUS, 16'h0001);
        host.stall = 0;
        host.rd(18'h00004, d, r);
        ck(r, `TSIE_RESP_DECERR);
        host.wr(18'h00004, 16'hFFFF, r);
        ck(r, `TSIE_RESP_DECERR);
    endtask
    task stop_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_status;
        t_cmd;
        t_events;
        t_pin;
        stop_test;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #40000;
        n_errors++;
        stop_test;
    end
endmodule
